/* File: design/adc_conversion_sequencer.sv */
// Sequencer for normal and urgent conversions of the converter.
// Assumes settings and strobes come from logic on the same clock,
// the trigger pin is asynchronous, and analog_data is valid at done.
`timescale 1ns/1ps
module adc_conversion_sequencer import adc_seq_pkg::*; (
	input wire logic clock, // 250 MHz clock
	input wire logic rst, // Synchronous reset
	input wire logic conv_repeat, // Repeat bit
	input wire logic conv_scan, // Scan bit
	input wire logic [1:0] irq_batch_sel, // Batch code
	input wire logic gap_enable, // Repeat interval enable
	input wire logic [CH_W-1:0] chan_sel_reg, // Channel or scan end
	input wire logic idle_keep_run, // Run on in standby
	input wire logic standby, // Chip in standby
	input wire logic norm_sw_go, // Normal software start
	input wire logic norm_hw_en, // Normal hardware start on
	input wire logic norm_hw_src_sel, // 0 pin, 1 timer 0
	input wire logic urgent_sw_go, // Urgent software start
	input wire logic urgent_hw_en, // Urgent hardware start on
	input wire logic urgent_hw_src_sel, // 0 pin, 1 timer 1
	input wire logic [CH_W-1:0] urgent_chan_sel, // Urgent channel
	input wire logic ext_trig_pin, // Trigger pin
	input wire logic timer0_trig, // Timer 0 pulse
	input wire logic timer1_trig, // Timer 1 pulse
	input wire logic norm_end_rd, // Normal end flag read
	input wire logic urgent_end_rd, // Urgent end flag read
	input wire logic [RES_W-1:0] analog_data, // Converter result
	input wire logic [CH_W-1:0] slot_rd_idx, // Result slot to read
	output logic norm_busy_flag, // Normal busy
	output logic norm_end_flag, // Normal end
	output logic urgent_busy_flag, // Urgent busy
	output logic urgent_end_flag, // Urgent end
	output logic conv_done_irq, // Normal done pulse
	output logic urgent_done_irq, // Urgent done pulse
	output logic [CH_W-1:0] sample_chan, // Channel to sample
	output logic [RES_W-1:0] result_slot_data, // Selected slot
	output logic [RES_W-1:0] urgent_result_reg // Urgent result
);
	conv_if cv();

	seq_state_e state_reg;
	seq_state_e state_next;
	seq_state_e ret_reg;
	seq_state_e ret_next;
	logic [CH_W-1:0] chan_reg;
	logic [CH_W-1:0] chan_next;
	logic [CH_W-1:0] chan_adv;
	logic [2:0] batch_reg;
	logic [2:0] batch_next;
	logic [2:0] batch_len;
	logic rep_reg;
	logic rep_next;
	logic scan_reg;
	logic scan_next;
	logic urg_pend_reg;
	logic urg_pend_next;
	logic restart_reg;
	logic restart_next;
	logic busy_reg;
	logic busy_next;
	logic urg_busy_reg;
	logic urg_busy_next;
	logic end_reg;
	logic urg_end_reg;
	logic irq_reg;
	logic urg_irq_reg;
	logic [CH_W-1:0] samp_chan_reg;
	logic [CH_W-1:0] samp_chan_next;
	logic [RES_W-1:0] urg_res_reg;
	logic trig_s1_reg;
	logic trig_s2_reg;
	logic trig_s3_reg;
	logic halt_q_reg;
	logic [2:0] gap_cnt_reg;
	logic gap_run_reg;
	logic trig_fall;
	logic norm_go;
	logic urg_go;
	logic halt;
	logic halt_exit;
	logic grp_end;
	logic norm_run;
	logic norm_init;
	logic norm_launch;
	logic urg_launch;
	seq_state_e urg_ret;
	seq_state_e nxt;
	logic start_pulse;
	logic abort_pulse;
	logic wr_norm;
	logic wr_urg;
	logic end_set;
	logic urg_end_set;
	logic gap_start;
	logic gap_stop;
	logic [CH_W-1:0] store_addr;

	assign cv.start = start_pulse;
	assign cv.abort = abort_pulse;

	assign norm_busy_flag = busy_reg;
	assign norm_end_flag = end_reg;
	assign urgent_busy_flag = urg_busy_reg;
	assign urgent_end_flag = urg_end_reg;
	assign conv_done_irq = irq_reg;
	assign urgent_done_irq = urg_irq_reg;
	assign sample_chan = samp_chan_reg;
	assign urgent_result_reg = urg_res_reg;

	conv_engine u_engine (
		.clock(clock),
		.rst(rst),
		.cv(cv.engine)
	);

	result_mem u_mem (
		.clock(clock),
		.rst(rst),
		.we(wr_norm),
		.waddr(store_addr),
		.wdata(analog_data),
		.raddr(slot_rd_idx),
		.rdata(result_slot_data)
	);

	// Pin synchroniser; the edge detector looks only at later stages
	always_ff @(posedge clock) begin
		if (rst) begin
			trig_s1_reg <= 1'b1;
			trig_s2_reg <= 1'b1;
			trig_s3_reg <= 1'b1;
		end else begin
			trig_s1_reg <= ext_trig_pin;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
		end
	end

	assign trig_fall = trig_s3_reg && !trig_s2_reg;
	assign norm_go = norm_sw_go || (norm_hw_en && (norm_hw_src_sel ? timer0_trig : trig_fall));
	assign urg_go = urgent_sw_go || (urgent_hw_en && (urgent_hw_src_sel ? timer1_trig : trig_fall));

	assign halt = standby && !idle_keep_run;
	assign halt_exit = halt_q_reg && !halt;

	always_ff @(posedge clock) begin
		if (rst) begin
			halt_q_reg <= FLAG_RST;
		end else begin
			halt_q_reg <= halt;
		end
	end

	// Batch code 11 is undefined and behaves as one conversion per batch
	always_comb begin
		unique case (irq_batch_sel)
			BATCH_4: batch_len = BATCH_4_LAST;
			BATCH_8: batch_len = BATCH_8_LAST;
			default: batch_len = BATCH_RST;
		endcase
	end

	// A group is one conversion, one batch or one full scan
	assign grp_end = scan_reg ? (chan_reg == chan_sel_reg) : (!rep_reg || batch_reg == batch_len);
	assign chan_adv = scan_reg ? (grp_end ? CHAN_RST : chan_reg + 4'h1) : chan_sel_reg;
	assign store_addr = scan_reg ? chan_reg : {1'b0, batch_reg};
	assign norm_run = state_reg == ST_CONV || state_reg == ST_GAP || (state_reg == ST_URG && ret_reg != ST_IDLE);

	always_comb begin
		state_next = state_reg;
		ret_next = ret_reg;
		chan_next = chan_reg;
		batch_next = batch_reg;
		rep_next = rep_reg;
		scan_next = scan_reg;
		urg_pend_next = urg_pend_reg;
		restart_next = restart_reg;
		busy_next = busy_reg;
		urg_busy_next = urg_busy_reg;
		samp_chan_next = samp_chan_reg;
		start_pulse = 1'b0;
		abort_pulse = 1'b0;
		wr_norm = 1'b0;
		wr_urg = 1'b0;
		end_set = 1'b0;
		urg_end_set = 1'b0;
		gap_start = 1'b0;
		gap_stop = 1'b0;
		norm_init = 1'b0;
		norm_launch = 1'b0;
		urg_launch = 1'b0;
		urg_ret = ST_IDLE;
		nxt = ST_CONV;
		if (halt) begin
			abort_pulse = 1'b1;
			gap_stop = 1'b1;
			state_next = ST_IDLE;
			busy_next = 1'b0;
			urg_busy_next = 1'b0;
			urg_pend_next = 1'b0;
			restart_next = restart_reg || (norm_run && rep_reg);
		end else if (halt_exit && restart_reg) begin
			restart_next = 1'b0;
			norm_init = 1'b1;
			norm_launch = 1'b1;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (norm_go) begin
						norm_init = 1'b1;
						norm_launch = 1'b1;
					end
					if (urg_go) begin
						urg_launch = 1'b1;
						urg_ret = norm_go ? ST_CONV : ST_IDLE;
					end
				end
				ST_CONV: begin
					if (urg_go) begin
						urg_pend_next = 1'b1;
					end
					if (norm_go) begin
						wr_norm = cv.sampled;
						norm_init = 1'b1;
						norm_launch = 1'b1;
					end else if (cv.done) begin
						wr_norm = 1'b1;
						end_set = grp_end;
						chan_next = chan_adv;
						batch_next = grp_end ? BATCH_RST : batch_reg + 3'h1;
						if (!rep_reg) begin
							if (grp_end) begin
								nxt = ST_IDLE;
								busy_next = 1'b0;
							end
						end else if (!conv_repeat) begin
							nxt = ST_IDLE;
							busy_next = 1'b0;
						end else if (grp_end && gap_enable) begin
							nxt = ST_GAP;
							busy_next = 1'b0;
							gap_start = 1'b1;
						end
						if (urg_pend_reg || urg_go) begin
							urg_launch = 1'b1;
							urg_ret = nxt;
						end else begin
							state_next = nxt;
							if (nxt == ST_CONV) begin
								start_pulse = 1'b1;
								samp_chan_next = chan_adv;
							end
						end
					end
				end
				ST_URG: begin
					// Further urgent requests fall through untouched here
					if (norm_go) begin
						norm_init = 1'b1;
						gap_stop = 1'b1;
						ret_next = ST_CONV;
					end
					if (cv.done) begin
						wr_urg = 1'b1;
						urg_end_set = 1'b1;
						urg_busy_next = 1'b0;
						state_next = norm_go ? ST_CONV : ret_reg;
						if (norm_go || ret_reg == ST_CONV) begin
							start_pulse = 1'b1;
							samp_chan_next = norm_go ? (conv_scan ? CHAN_RST : chan_sel_reg) : chan_reg;
						end
					end
				end
				ST_GAP: begin
					if (norm_go) begin
						norm_init = 1'b1;
						norm_launch = 1'b1;
						gap_stop = 1'b1;
					end else if (urg_go) begin
						urg_launch = 1'b1;
						urg_ret = ST_GAP;
					end else if (!gap_run_reg) begin
						state_next = ST_CONV;
						busy_next = 1'b1;
						start_pulse = 1'b1;
						samp_chan_next = chan_reg;
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
		if (norm_init) begin
			rep_next = conv_repeat;
			scan_next = conv_scan;
			chan_next = conv_scan ? CHAN_RST : chan_sel_reg;
			batch_next = BATCH_RST;
			busy_next = 1'b1;
		end
		if (norm_launch) begin
			state_next = ST_CONV;
			abort_pulse = 1'b1;
			start_pulse = 1'b1;
			samp_chan_next = conv_scan ? CHAN_RST : chan_sel_reg;
		end
		if (urg_launch) begin
			state_next = ST_URG;
			ret_next = urg_ret;
			urg_pend_next = 1'b0;
			urg_busy_next = 1'b1;
			start_pulse = 1'b1;
			abort_pulse = 1'b0;
			samp_chan_next = urgent_chan_sel;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			ret_reg <= ST_IDLE;
			urg_pend_reg <= FLAG_RST;
			restart_reg <= FLAG_RST;
		end else begin
			state_reg <= state_next;
			ret_reg <= ret_next;
			urg_pend_reg <= urg_pend_next;
			restart_reg <= restart_next;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			chan_reg <= CHAN_RST;
			batch_reg <= BATCH_RST;
			rep_reg <= FLAG_RST;
			scan_reg <= FLAG_RST;
			samp_chan_reg <= CHAN_RST;
		end else begin
			chan_reg <= chan_next;
			batch_reg <= batch_next;
			rep_reg <= rep_next;
			scan_reg <= scan_next;
			samp_chan_reg <= samp_chan_next;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			busy_reg <= FLAG_RST;
			urg_busy_reg <= FLAG_RST;
		end else begin
			busy_reg <= busy_next;
			urg_busy_reg <= urg_busy_next;
		end
	end

	// A set in the same cycle as a read keeps the flag up
	always_ff @(posedge clock) begin
		if (rst) begin
			end_reg <= FLAG_RST;
		end else if (end_set) begin
			end_reg <= 1'b1;
		end else if (norm_end_rd) begin
			end_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			urg_end_reg <= FLAG_RST;
		end else if (urg_end_set) begin
			urg_end_reg <= 1'b1;
		end else if (urgent_end_rd) begin
			urg_end_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_reg <= FLAG_RST;
			urg_irq_reg <= FLAG_RST;
		end else begin
			irq_reg <= end_set;
			urg_irq_reg <= urg_end_set;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			urg_res_reg <= RES_RST;
		end else if (wr_urg) begin
			urg_res_reg <= analog_data;
		end
	end

	// The gap keeps counting while an urgent conversion runs
	always_ff @(posedge clock) begin
		if (rst || gap_stop) begin
			gap_run_reg <= FLAG_RST;
			gap_cnt_reg <= BATCH_RST;
		end else if (gap_start) begin
			gap_run_reg <= 1'b1;
			gap_cnt_reg <= 3'h0;
		end else if (gap_run_reg && cv.tick) begin
			gap_cnt_reg <= gap_cnt_reg + 3'h1;
			if (gap_cnt_reg == GAP_LAST) begin
				gap_run_reg <= 1'b0;
			end
		end
	end
endmodule // adc_conversion_sequencer

/* File: design/adc_seq_pkg.sv */
// Constants, codes and state type for the conversion sequencer.
// Assumes one 250 MHz clock and a conversion clock made by a divider.
package adc_seq_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_CLK_PERIOD_NS = 500;
	localparam int CONV_DIV = CONV_CLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [7:0] CONV_DIV_LAST = 8'(CONV_DIV - 1);
	localparam int CONV_TICKS = 2;
	localparam logic [1:0] CONV_LAST = 2'(CONV_TICKS - 1);
	localparam logic [1:0] SAMPLE_AT = 2'h1;
	localparam int GAP_TICKS = 8;
	localparam logic [2:0] GAP_LAST = 3'(GAP_TICKS - 1);
	localparam int RES_W = 10;
	localparam int CH_W = 4;
	localparam int SLOT_N = 16;
	localparam logic [1:0] BATCH_1 = 2'h0;
	localparam logic [1:0] BATCH_4 = 2'h1;
	localparam logic [1:0] BATCH_8 = 2'h2;
	localparam logic [2:0] BATCH_4_LAST = 3'h3;
	localparam logic [2:0] BATCH_8_LAST = 3'h7;
	localparam logic FLAG_RST = 1'b0;
	localparam logic [CH_W-1:0] CHAN_RST = 4'h0;
	localparam logic [2:0] BATCH_RST = 3'h0;
	localparam logic [RES_W-1:0] RES_RST = 10'h000;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CONV = 4'b0010,
		ST_URG = 4'b0100,
		ST_GAP = 4'b1000
	} seq_state_e;
endpackage

/* File: design/conv_if.sv */
// Handshake between the sequencer and the conversion timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface conv_if;
	logic start;
	logic abort;
	logic tick;
	logic sampled;
	logic done;
	modport seq(output start, abort, input tick, sampled, done);
	modport engine(input start, abort, output tick, sampled, done);
endinterface

/* File: design/conv_engine.sv */
// Conversion clock divider and two-tick conversion timer.
// Assumes start and abort are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module conv_engine import adc_seq_pkg::*; (
	input wire logic clock, // System clock
	input wire logic rst, // Synchronous reset
	conv_if.engine cv // Sequencer side
);
	logic [7:0] div_reg;
	logic tick_reg;
	logic [1:0] phase_reg;
	logic run_reg;
	logic sampled_reg;
	logic done_reg;

	assign cv.tick = tick_reg;
	assign cv.sampled = sampled_reg;
	assign cv.done = done_reg;

	// Free-running divider so the gap count keeps time during urgent work
	always_ff @(posedge clock) begin
		if (rst || div_reg == CONV_DIV_LAST) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		tick_reg <= !rst && div_reg == CONV_DIV_LAST;
	end

	always_ff @(posedge clock) begin
		done_reg <= 1'b0;
		// A start beside an abort is a restart, so the start must win
		if (rst || (cv.abort && !cv.start)) begin
			run_reg <= 1'b0;
			phase_reg <= 2'h0;
			sampled_reg <= 1'b0;
		end else if (cv.start) begin
			run_reg <= 1'b1;
			phase_reg <= 2'h0;
			sampled_reg <= 1'b0;
		end else if (run_reg && tick_reg) begin
			if (phase_reg == CONV_LAST) begin
				run_reg <= 1'b0;
				phase_reg <= 2'h0;
				sampled_reg <= 1'b0;
				done_reg <= 1'b1;
			end else begin
				phase_reg <= phase_reg + 2'h1;
				sampled_reg <= (phase_reg + 2'h1) == SAMPLE_AT;
			end
		end
	end
endmodule // conv_engine

/* File: design/result_mem.sv */
// Result slots with a registered read port.
// Assumes write strobe and read index on the same clock.
`timescale 1ns/1ps
module result_mem import adc_seq_pkg::*; (
	input wire logic clock, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic we, // Write strobe
	input wire logic [CH_W-1:0] waddr, // Write slot
	input wire logic [RES_W-1:0] wdata, // Write data
	input wire logic [CH_W-1:0] raddr, // Read slot
	output logic [RES_W-1:0] rdata // Read data, one cycle late
);
	logic [RES_W-1:0] mem [SLOT_N];

	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Slots are never reset, so an unwritten slot reads as unknown
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata <= RES_RST;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule // result_mem

/* File: bench/analog_src.sv */
// Analog inputs on the far side of the sequencer; each channel holds a steady level.
// Assumes sample_chan is registered on clock; a level depends only on its channel.
`timescale 1ns/1ps
module analog_src import adc_seq_pkg::*; #(
	parameter logic [5:0] FILL = 6'h15 // Low bits shared by every channel
) (
	input wire logic clock, // System clock
	input wire logic [CH_W-1:0] sample_chan, // Channel being converted
	output logic [RES_W-1:0] analog_data // Level of that channel
);
	// Registered so a channel switch shows one cycle late, like a settling input
	always_ff @(posedge clock) begin
		analog_data <= {sample_chan, FILL};
	end
endmodule // analog_src

/* File: bench/adc_seq_asserts.sv */
// Port-level checks on the conversion sequencer.
// Assumes it is bound to adc_conversion_sequencer; one clock, synchronous reset.
`timescale 1ns/1ps
module adc_seq_asserts import adc_seq_pkg::*; (
	input wire logic clock, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic conv_repeat, // Repeat bit
	input wire logic gap_enable, // Repeat interval enable
	input wire logic idle_keep_run, // Run on in standby
	input wire logic standby, // Chip in standby
	input wire logic norm_sw_go, // Normal software start
	input wire logic norm_end_rd, // Normal end flag read
	input wire logic urgent_end_rd, // Urgent end flag read
	input wire logic norm_busy_flag, // Normal busy
	input wire logic norm_end_flag, // Normal end
	input wire logic urgent_busy_flag, // Urgent busy
	input wire logic urgent_end_flag, // Urgent end
	input wire logic conv_done_irq, // Normal done pulse
	input wire logic urgent_done_irq // Urgent done pulse
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_go_busy;
		norm_sw_go && !urgent_busy_flag && !(standby && !idle_keep_run) |=> norm_busy_flag;
	endproperty
	a_go_busy: assert property (p_go_busy) else $error("busy not raised after start");
	property p_single_end;
		conv_done_irq && !conv_repeat |-> !norm_busy_flag;
	endproperty
	a_single_end: assert property (p_single_end) else $error("busy still set at single end");
	property p_repeat_busy;
		conv_done_irq && conv_repeat && !gap_enable |-> norm_busy_flag;
	endproperty
	a_repeat_busy: assert property (p_repeat_busy) else $error("busy dropped in repeat");
	property p_irq_end;
		conv_done_irq |-> norm_end_flag;
	endproperty
	a_irq_end: assert property (p_irq_end) else $error("done pulse without end flag");
	property p_irq_pulse;
		conv_done_irq |=> !conv_done_irq [*8];
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("done pulse too long");
	property p_end_clear;
		norm_end_rd |=> !norm_end_flag || conv_done_irq;
	endproperty
	a_end_clear: assert property (p_end_clear) else $error("end flag kept after read");
	property p_urg_done;
		urgent_done_irq |-> urgent_end_flag && !urgent_busy_flag;
	endproperty
	a_urg_done: assert property (p_urg_done) else $error("urgent flags wrong at done");
	property p_urg_clear;
		urgent_end_rd |=> !urgent_end_flag || urgent_done_irq;
	endproperty
	a_urg_clear: assert property (p_urg_clear) else $error("urgent end kept after read");
	property p_halt;
		standby && !idle_keep_run |=> !norm_busy_flag && !urgent_busy_flag;
	endproperty
	a_halt: assert property (p_halt) else $error("busy during standby halt");
	property p_reset;
		disable iff (1'b0) rst |=> !norm_busy_flag && !norm_end_flag && !urgent_busy_flag && !urgent_end_flag;
	endproperty
	a_reset: assert property (p_reset) else $error("flags set after reset");
endmodule // adc_seq_asserts

/* File: bench/tb_top.sv */
// Self-checking bench for the conversion sequencer, with the analog source model.
// Assumes a 250 MHz clock; all inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module tb_top import adc_seq_pkg::*; ;
	localparam logic [5:0] FILL = 6'h15;
	logic clock, rst, conv_repeat, conv_scan, gap_enable, idle_keep_run, standby, norm_sw_go, norm_hw_en;
	logic norm_hw_src_sel, urgent_sw_go, ext_trig_pin, timer0_trig, norm_end_rd, urgent_end_rd;
	logic urgent_hw_en, urgent_hw_src_sel, timer1_trig;
	logic [1:0] irq_batch_sel;
	logic [CH_W-1:0] chan_sel_reg, urgent_chan_sel, slot_rd_idx, sample_chan;
	logic [RES_W-1:0] analog_data, result_slot_data, urgent_result_reg;
	logic norm_busy_flag, norm_end_flag, urgent_busy_flag, urgent_end_flag, conv_done_irq, urgent_done_irq;
	int mismatches = 0;
	int num_checks = 0;
	int n, i, b, nb;
	always #2 clock = ~clock;
	adc_conversion_sequencer uut (.clock(clock), .rst(rst), .conv_repeat(conv_repeat), .conv_scan(conv_scan),
		.irq_batch_sel(irq_batch_sel), .gap_enable(gap_enable), .chan_sel_reg(chan_sel_reg),
		.idle_keep_run(idle_keep_run), .standby(standby), .norm_sw_go(norm_sw_go), .norm_hw_en(norm_hw_en),
		.norm_hw_src_sel(norm_hw_src_sel), .urgent_sw_go(urgent_sw_go), .urgent_hw_en(urgent_hw_en),
		.urgent_hw_src_sel(urgent_hw_src_sel), .urgent_chan_sel(urgent_chan_sel), .ext_trig_pin(ext_trig_pin),
		.timer0_trig(timer0_trig), .timer1_trig(timer1_trig),
		.norm_end_rd(norm_end_rd), .urgent_end_rd(urgent_end_rd),
		.analog_data(analog_data), .slot_rd_idx(slot_rd_idx), .norm_busy_flag(norm_busy_flag),
		.norm_end_flag(norm_end_flag), .urgent_busy_flag(urgent_busy_flag), .urgent_end_flag(urgent_end_flag),
		.conv_done_irq(conv_done_irq), .urgent_done_irq(urgent_done_irq), .sample_chan(sample_chan),
		.result_slot_data(result_slot_data), .urgent_result_reg(urgent_result_reg));
	analog_src #(.FILL(FILL)) src (.clock(clock), .sample_chan(sample_chan), .analog_data(analog_data));
	task automatic finish_test;
		if (mismatches == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic checkf(input string name, input logic seen, input logic exp);
		check(name, RES_W'(seen), RES_W'(exp));
	endtask
	task automatic step(input int k);
		repeat (k) begin
			@(posedge clock);
			#1;
		end
	endtask
	function automatic logic [RES_W-1:0] val(input int ch);
		return {4'(ch), FILL};
	endfunction
	function automatic logic sig(input int s);
		case (s)
			0: return conv_done_irq;
			1: return urgent_done_irq;
			2: return !norm_busy_flag;
			default: return norm_busy_flag;
		endcase
	endfunction
	// Bounded wait; t returns the cycles spent
	task automatic wait_for(input int s, input int lim, output int t);
		t = 0;
		while (sig(s) !== 1'b1 && t < lim) begin
			step(1);
			t++;
		end
		checkf("wait", t < lim, 1'b1);
	endtask
	task automatic slot_is(input int idx, input logic [RES_W-1:0] e);
		slot_rd_idx = 4'(idx);
		step(2);
		check("slot", result_slot_data, e);
	endtask
	task automatic start(input logic r, input logic s, input logic [1:0] bs, input logic g, input int ch);
		conv_repeat = r;
		conv_scan = s;
		irq_batch_sel = bs;
		gap_enable = g;
		chan_sel_reg = 4'(ch);
		norm_sw_go = 1'b1;
		step(1);
		norm_sw_go = 1'b0;
		step(1);
		checkf("busy", norm_busy_flag, 1'b1);
	endtask
	task automatic pulse_rd(input logic urg);
		norm_end_rd = !urg;
		urgent_end_rd = urg;
		step(1);
		norm_end_rd = 1'b0;
		urgent_end_rd = 1'b0;
		step(1);
	endtask
	initial begin
		#(CLK_PERIOD_NS * 30000);
		mismatches++;
		finish_test();
	end
	initial begin
		clock = 0; rst = 1; conv_repeat = 0; conv_scan = 0; gap_enable = 0; idle_keep_run = 0; standby = 0;
		norm_sw_go = 0; norm_hw_en = 0; norm_hw_src_sel = 0; urgent_sw_go = 0; ext_trig_pin = 1; timer0_trig = 0;
		norm_end_rd = 0; urgent_end_rd = 0; irq_batch_sel = 0; chan_sel_reg = 0; urgent_chan_sel = 0; slot_rd_idx = 0;
		urgent_hw_en = 0;
		urgent_hw_src_sel = 0;
		timer1_trig = 0;
		step(5);
		rst = 0;
		checkf("busy", norm_busy_flag | urgent_busy_flag, 1'b0);
		checkf("end", norm_end_flag | urgent_end_flag, 1'b0);
		start(0, 0, 2'h0, 0, 3);
		wait_for(0, 300, n);
		checkf("end", norm_end_flag, 1'b1);
		checkf("busy", norm_busy_flag, 1'b0);
		slot_is(0, val(3));
		pulse_rd(0);
		checkf("end", norm_end_flag, 1'b0);
		// Scan wide enough that every slot just past a batch holds a known level
		start(0, 1, 2'h0, 0, 8);
		wait_for(0, 2300, n);
		checkf("busy", norm_busy_flag, 1'b0);
		for (i = 0; i < 9; i++) slot_is(i, val(i));
		for (b = 0; b < 3; b++) begin
			nb = (b == 0) ? 1 : (b == 1) ? 4 : 8;
			start(1, 0, 2'(b), 0, (b == 0) ? 7 : b + 4);
			wait_for(0, 260 * nb, n);
			checkf("busy", norm_busy_flag, 1'b1);
			slot_is(nb - 1, val((b == 0) ? 7 : b + 4));
			slot_is(nb, val(nb));
			conv_repeat = 0;
			wait_for(2, 260, n);
			step(300);
			checkf("busy", norm_busy_flag, 1'b0);
		end
		start(1, 1, 2'h0, 1, 1);
		wait_for(0, 600, n);
		wait_for(2, 10, n);
		wait_for(3, 1100, n);
		checkf("gap", n >= 870 && n <= 1005, 1'b1);
		wait_for(0, 600, n);
		wait_for(3, 1100, n);
		standby = 1;
		step(2);
		checkf("busy", norm_busy_flag, 1'b0);
		standby = 0;
		wait_for(3, 10, n);
		conv_repeat = 0;
		wait_for(2, 600, n);
		start(0, 0, 2'h0, 0, 4);
		standby = 1;
		step(2);
		standby = 0;
		step(600);
		checkf("busy", norm_busy_flag, 1'b0);
		urgent_chan_sel = 4'h9;
		urgent_sw_go = 1;
		step(1);
		urgent_sw_go = 0;
		check("chan", RES_W'(sample_chan), 10'h009);
		step(2);
		// Second request lands well inside the first conversion; it must not queue
		urgent_sw_go = 1;
		step(1);
		urgent_sw_go = 0;
		wait_for(1, 300, n);
		checkf("ubusy", urgent_busy_flag, 1'b0);
		checkf("uend", urgent_end_flag, 1'b1);
		check("ures", urgent_result_reg, val(9));
		pulse_rd(1);
		checkf("uend", urgent_end_flag, 1'b0);
		checkf("ubusy", urgent_busy_flag, 1'b0);
		pulse_rd(0);
		start(0, 1, 2'h0, 0, 3);
		step(50);
		urgent_chan_sel = 4'hc;
		urgent_sw_go = 1;
		step(1);
		urgent_sw_go = 0;
		wait_for(1, 600, n);
		check("ures", urgent_result_reg, val(12));
		checkf("busy", norm_busy_flag, 1'b1);
		wait_for(0, 1200, n);
		for (i = 0; i < 4; i++) slot_is(i, val(i));
		for (b = 0; b < 2; b++) begin
			conv_scan = 0;
			chan_sel_reg = 4'(b + 5);
			urgent_chan_sel = 4'(b + 10);
			norm_hw_src_sel = b[0];
			urgent_hw_src_sel = b[0];
			norm_hw_en = 1;
			urgent_hw_en = 1;
			ext_trig_pin = b[0];
			timer0_trig = b[0];
			timer1_trig = b[0];
			step(1);
			timer0_trig = 0;
			timer1_trig = 0;
			wait_for(3, 8, n);
			checkf("ubusy", urgent_busy_flag, 1'b1);
			wait_for(1, 300, n);
			check("ures", urgent_result_reg, val(b + 10));
			wait_for(0, 300, n);
			slot_is(0, val(b + 5));
			ext_trig_pin = 1;
			norm_hw_en = 0;
			urgent_hw_en = 0;
			step(5);
		end
		finish_test();
	end
endmodule // tb_top
bind adc_conversion_sequencer adc_seq_asserts chk (.clock(clock), .rst(rst), .conv_repeat(conv_repeat),
	.gap_enable(gap_enable), .idle_keep_run(idle_keep_run), .standby(standby), .norm_sw_go(norm_sw_go),
	.norm_end_rd(norm_end_rd), .urgent_end_rd(urgent_end_rd), .norm_busy_flag(norm_busy_flag),
	.norm_end_flag(norm_end_flag), .urgent_busy_flag(urgent_busy_flag), .urgent_end_flag(urgent_end_flag),
	.conv_done_irq(conv_done_irq), .urgent_done_irq(urgent_done_irq));
